// [verilog/dbafsm.sv]
// Purpose: hands the shared buffer between host and protocol controller
// Assumes: i_clk is the master clock; the protocol controller runs on o_ctrl_clk, i_clk divided by six
// Notes:   grant and strobes are partly combinational so ownership turns at once
`timescale 1ns/100ps
`include "dbafsm_defs.svh"
`default_nettype none

module dbafsm (
    input  wire logic                         i_clk,
    input  wire logic                         i_rst,
    input  wire logic                         i_ctrl_chip_reset,
    input  wire logic                         i_speed_16m,
    input  wire logic                         i_buffer_claim_select_n,
    input  wire logic                         i_data_request,
    input  wire logic                         i_chip_read_strobe_n,
    input  wire logic                         i_chip_write_strobe_n,
    input  wire logic                         i_control_cycle_strobe_n,
    input  wire logic                         i_latched_write,
    input  wire logic                         i_latched_addr_bit2,
    input  wire logic                         i_ctrl_irq,
    output logic                              o_ctrl_read_strobe_n,
    output logic                              o_ctrl_write_strobe_n,
    output logic                              o_ctrl_strobe_oe,
    output logic                              o_buffer_access_grant,
    output logic                              o_buffer_access_request,
    output logic [`DBAFSM_STATE_W-1:0]        o_buffer_fsm_state,
    output logic                              o_reg_file_select,
    output logic                              o_host_irq_n,
    output logic                              o_ctrl_clk
);
    import dbafsm_pkg::*;

    dbafsm_state_t               state_q;      // current handover state
    dbafsm_state_t               state_d;      // next handover state
    logic                        data_request_neg_q;  // data request caught on falling edge
    logic                        synced_data_request; // data request as the machine sees it
    logic                        claim;        // controller claims the buffer
    logic                        grant_q;      // registered part of grant
    logic                        request_q;    // registered request
    logic [2:0]                  div_cnt_q;    // divide-by-six phase
    logic                        ctrl_clk_q;   // divided controller clock
    logic                        reg_sel_q;    // registered register select
    logic                        irq_n_q;      // inverted interrupt

    assign claim = ~i_buffer_claim_select_n;

    // falling edge resample
    // a half-cycle stage keeps setup margin at 16 MHz; at 8 MHz the input
    // is already timed to the system clock and goes straight through
    always_ff @(negedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            data_request_neg_q <= 1'b0;
        end else begin
            data_request_neg_q <= i_data_request;
        end
    end

    // select which copy of data request steers the machine
    assign synced_data_request = i_speed_16m ? data_request_neg_q : i_data_request;

    // next-state logic
    always_comb begin
        state_d = state_q;
        case (state_q)
            DBAFSM_IDLE: begin
                if (claim) begin
                    state_d = DBAFSM_PENDING;
                end
            end
            DBAFSM_PENDING: begin
                if (synced_data_request) begin
                    state_d = DBAFSM_ACTIVE;
                end
            end
            DBAFSM_ACTIVE: begin
                if (!claim && synced_data_request) begin
                    state_d = DBAFSM_IDLE;
                end else if (claim && !synced_data_request) begin
                    state_d = DBAFSM_THROTTLE;
                end else if (!claim && !synced_data_request) begin
                    // both dropped together: nothing left to resume safely
                    state_d = DBAFSM_THROTTLE;
                end
            end
            DBAFSM_THROTTLE: begin
                if (synced_data_request) begin
                    state_d = DBAFSM_KICKSTART;
                end
            end
            // the controller is relied on to reclaim inside one cycle
            DBAFSM_KICKSTART: begin
                if (claim) begin
                    state_d = DBAFSM_ACTIVE;
                end else begin
                    state_d = DBAFSM_IDLE;
                end
            end
            default: begin
                state_d = DBAFSM_IDLE;
            end
        endcase
    end

    // reset returns idle
    // controller reset is synchronous so it cannot glitch the state mid-edge
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= DBAFSM_IDLE;
        end else if (i_ctrl_chip_reset) begin
            state_q <= DBAFSM_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // grant and request follow the next state so they line up with it
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            grant_q   <= 1'b0;
            request_q <= 1'b0;
        end else if (i_ctrl_chip_reset) begin
            grant_q   <= 1'b0;
            request_q <= 1'b0;
        end else begin
            case (state_d)
                DBAFSM_IDLE: begin
                    grant_q   <= 1'b0;
                    request_q <= 1'b0;
                end
                DBAFSM_PENDING: begin
                    grant_q   <= 1'b0;
                    request_q <= 1'b1;
                end
                DBAFSM_ACTIVE: begin
                    grant_q   <= 1'b1;
                    request_q <= 1'b1;
                end
                // request held in kickstart, grant added below
                default: begin
                    grant_q   <= 1'b0;
                    request_q <= 1'b1;
                end
            endcase
        end
    end

    // instant grant in kickstart
    // the first byte may follow the reclaim within 40 ns, shorter than a
    // clock, so the grant cannot wait for the next edge
    assign o_buffer_access_grant   = grant_q |
                                     ((state_q == DBAFSM_KICKSTART) & claim);
    assign o_buffer_access_request = request_q;
    assign o_buffer_fsm_state      = state_q;

    // strobe generation toward the memory control logic
    always_comb begin
        o_ctrl_read_strobe_n  = 1'b1;
        o_ctrl_write_strobe_n = 1'b1;
        case (state_q)
            DBAFSM_IDLE: begin
                o_ctrl_read_strobe_n  = i_control_cycle_strobe_n | i_latched_write;
                o_ctrl_write_strobe_n = i_control_cycle_strobe_n | ~i_latched_write;
            end
            DBAFSM_ACTIVE: begin
                if (claim && synced_data_request) begin
                    o_ctrl_read_strobe_n  = i_chip_read_strobe_n;
                    o_ctrl_write_strobe_n = i_chip_write_strobe_n;
                end
            end
            // other states keep both strobes idle
            default: begin
                o_ctrl_read_strobe_n  = 1'b1;
                o_ctrl_write_strobe_n = 1'b1;
            end
        endcase
    end

    // release strobe pins
    // the controller turns these pins round while it claims the buffer
    assign o_ctrl_strobe_oe = i_buffer_claim_select_n;

    // divide by six
    // a free-running counter from reset; even ratio gives a 50% duty clock
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            div_cnt_q  <= 3'h0;
            ctrl_clk_q <= 1'b0;
        end else if (div_cnt_q == `DBAFSM_CLK_DIV - 3'h1) begin
            div_cnt_q  <= 3'h0;
            ctrl_clk_q <= 1'b0;
        end else begin
            div_cnt_q  <= div_cnt_q + 3'h1;
            ctrl_clk_q <= (div_cnt_q + 3'h1 >= `DBAFSM_CLK_HALF);
        end
    end

    assign o_ctrl_clk = ctrl_clk_q;

    // register select
    // low picks the auxiliary status/address register, high the file
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            reg_sel_q <= 1'b0;
        end else begin
            reg_sel_q <= i_latched_addr_bit2;
        end
    end

    assign o_reg_file_select = reg_sel_q;

    // inverted interrupt
    // reset value is the idle level of an active-low line
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            irq_n_q <= 1'b1;
        end else begin
            irq_n_q <= ~i_ctrl_irq;
        end
    end

    assign o_host_irq_n = irq_n_q;

endmodule

`default_nettype wire

// [verilog/dbafsm_defs.svh]
// Purpose: constants for the direct buffer access state machine
// Assumes: included by its bare name; definitions only
// Notes:   field positions and counts live here, types live in dbafsm_pkg
`ifndef DBAFSM_DEFS_SVH
`define DBAFSM_DEFS_SVH

// master to controller clock divide ratio
`define DBAFSM_CLK_DIV        3'h6
// half of the divide ratio, where the divided clock toggles
`define DBAFSM_CLK_HALF       3'h3
// width of the state code exposed for observation
`define DBAFSM_STATE_W        3
// host byte addresses of the two controller registers
`define DBAFSM_AUX_STAT_ADDR  28'h31E_0000
`define DBAFSM_REG_FILE_ADDR  28'h31E_0004
// reclaim window allowed to the controller after data request
`define DBAFSM_RECLAIM_NS     40

`endif

// [verilog/dbafsm_pkg.sv]
// Purpose: types for the direct buffer access state machine
// Assumes: nothing beyond SystemVerilog packages
// Notes:   state codes are the default enum values, 0 to 4 in listed order
package dbafsm_pkg;
    // the five handover states
    typedef enum logic [2:0] {
        DBAFSM_IDLE,
        DBAFSM_PENDING,
        DBAFSM_ACTIVE,
        DBAFSM_THROTTLE,
        DBAFSM_KICKSTART
    } dbafsm_state_t;
endpackage

// [tb/dbafsm_sva.sv]
// Purpose: concurrent checks on the buffer handover machine
// Assumes: transition checks use the direct data request path only
// Notes:   state codes come from the package enum
`timescale 1ns/100ps
`default_nettype none
module dbafsm_sva import dbafsm_pkg::*; (
    input wire logic       i_clk,
    input wire logic       i_rst,
    input wire logic       i_ctrl_chip_reset,
    input wire logic       i_speed_16m,
    input wire logic       i_buffer_claim_select_n,
    input wire logic       i_data_request,
    input wire logic       i_ctrl_irq,
    input wire logic       i_latched_addr_bit2,
    input wire logic       o_ctrl_strobe_oe,
    input wire logic       o_buffer_access_grant,
    input wire logic       o_buffer_access_request,
    input wire logic [2:0] o_buffer_fsm_state,
    input wire logic       o_reg_file_select,
    input wire logic       o_host_irq_n,
    input wire logic       o_ctrl_clk
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire logic [2:0] s = o_buffer_fsm_state;
    wire logic       c = ~i_buffer_claim_select_n;  // claim held
    wire logic       k = ~i_ctrl_chip_reset;        // no controller reset
    wire logic       d = ~i_speed_16m;              // data request seen without resync
    wire logic       g = o_buffer_access_grant;
    wire logic       r = o_buffer_access_request;
    // active, claim held, request withdrawn
    sequence s_stall;
        s == DBAFSM_ACTIVE && c && d && !i_data_request && k;
    endsequence
    a_idle_quiet: assert property (s == DBAFSM_IDLE |-> !g && !r)
        else $error("idle outputs");
    a_idle_claim: assert property (s == DBAFSM_IDLE && c && k |=> s == DBAFSM_PENDING)
        else $error("no pending");
    a_pend_wait: assert property (s == DBAFSM_PENDING && k && d
        |=> s == ($past(i_data_request) ? DBAFSM_ACTIVE : DBAFSM_PENDING)) else $error("pending");
    a_hold_req: assert property (s == DBAFSM_PENDING || s == DBAFSM_THROTTLE |-> r && !g)
        else $error("hold outputs");
    a_active_both: assert property (s == DBAFSM_ACTIVE |-> g && r)
        else $error("active outputs");
    a_active_done: assert property (s == DBAFSM_ACTIVE && !c && d && i_data_request && k
        |=> s == DBAFSM_IDLE) else $error("no idle");
    a_throttle_in: assert property (s_stall |=> s == DBAFSM_THROTTLE)
        else $error("no throttle");
    a_kick_exit: assert property (s == DBAFSM_KICKSTART && k
        |=> s == ($past(c) ? DBAFSM_ACTIVE : DBAFSM_IDLE)) else $error("kick exit");
    a_kick_grant: assert property (s == DBAFSM_KICKSTART |-> r && g == c)
        else $error("kick grant");
    a_oe_select: assert property (o_ctrl_strobe_oe == i_buffer_claim_select_n)
        else $error("strobe enable");
    a_clk_div: assert property ($rose(o_ctrl_clk)
        |=> o_ctrl_clk [*2] ##1 !o_ctrl_clk [*3] ##1 o_ctrl_clk) else $error("divider");
    a_irq_inv: assert property (!$past(i_rst) |-> o_host_irq_n == !$past(i_ctrl_irq)
        && o_reg_file_select == $past(i_latched_addr_bit2)) else $error("irq or select");
    a_chip_reset: assert property (i_ctrl_chip_reset |=> s == DBAFSM_IDLE && !g && !r)
        else $error("chip reset");
endmodule
bind dbafsm dbafsm_sva chk (.i_clk, .i_rst, .i_ctrl_chip_reset, .i_speed_16m,
    .i_buffer_claim_select_n, .i_data_request, .i_ctrl_irq, .i_latched_addr_bit2,
    .o_ctrl_strobe_oe, .o_buffer_access_grant, .o_buffer_access_request,
    .o_buffer_fsm_state, .o_reg_file_select, .o_host_irq_n, .o_ctrl_clk);
`default_nettype wire

// [tb/dbafsm_far.sv]
// Purpose: protocol controller and main arbiter stand-in
// Assumes: commands change just after a rising edge
// Notes:   released strobe lines rest high on their pull-ups
`timescale 1ns/100ps
`default_nettype none
module dbafsm_far (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_want,
    input  wire logic i_free,
    output logic      o_claim_n,
    output logic      o_data_request,
    output logic      o_rd_n,
    output logic      o_wr_n
);
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            {o_claim_n, o_data_request, o_rd_n, o_wr_n} <= 4'hb;
        end else begin
            o_claim_n      <= !i_want;
            o_data_request <= i_free;
            // strobes alternate so both never go low together
            o_rd_n    <= !(i_want && i_free && o_rd_n);
            o_wr_n    <= !(i_want && i_free && !o_rd_n);
        end
    end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Purpose: drives handover walks in both speed modes
// Assumes: state changes are the results the watcher retires
// Notes:   idle strobes, select and irq use random stimulus
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import dbafsm_pkg::*;
    localparam logic [4:0] NO = 5'h1f;  // no second note
    logic i_clk = 1'b0, i_rst = 1'b1, i_ctrl_chip_reset = 1'b0, i_speed_16m = 1'b0;
    logic i_control_cycle_strobe_n = 1'b1, i_latched_write = 1'b0;
    logic i_latched_addr_bit2 = 1'b0, i_ctrl_irq = 1'b0, want = 1'b0, free = 1'b0;
    wire logic i_buffer_claim_select_n, i_data_request, i_chip_read_strobe_n;
    wire logic i_chip_write_strobe_n, o_ctrl_read_strobe_n, o_ctrl_write_strobe_n;
    wire logic o_ctrl_strobe_oe, o_buffer_access_grant, o_buffer_access_request;
    wire logic o_reg_file_select, o_host_irq_n, o_ctrl_clk;
    wire logic [2:0] o_buffer_fsm_state;
    logic [2:0] prev = 3'h0;
    logic [4:0] expq[$];
    logic [31:0] rnd = 32'h0000_13a4;
    int fails = 0, checks = 0;
    always #10 i_clk = ~i_clk;
    dbafsm dut (.i_clk, .i_rst, .i_ctrl_chip_reset, .i_speed_16m, .i_buffer_claim_select_n,
        .i_data_request, .i_chip_read_strobe_n, .i_chip_write_strobe_n,
        .i_control_cycle_strobe_n, .i_latched_write, .i_latched_addr_bit2, .i_ctrl_irq,
        .o_ctrl_read_strobe_n, .o_ctrl_write_strobe_n, .o_ctrl_strobe_oe,
        .o_buffer_access_grant, .o_buffer_access_request, .o_buffer_fsm_state,
        .o_reg_file_select, .o_host_irq_n, .o_ctrl_clk);
    dbafsm_far far (.i_clk, .i_rst, .i_want(want), .i_free(free),
        .o_claim_n(i_buffer_claim_select_n), .o_data_request(i_data_request),
        .o_rd_n(i_chip_read_strobe_n), .o_wr_n(i_chip_write_strobe_n));
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic cmp(input logic [4:0] got, input logic [4:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // each state change retires the oldest note: state, grant, request
    always @(negedge i_clk) begin
        if (!i_rst && o_buffer_fsm_state !== prev)
            cmp({o_buffer_fsm_state, o_buffer_access_grant, o_buffer_access_request},
                expq.size() > 0 ? expq.pop_front() : NO);
        prev = o_buffer_fsm_state;
    end
    // command the far side, note expected states, wait bounded
    task automatic go(input logic w, input logic f, input logic [4:0] e1, input logic [4:0] e2);
        int n;
        @(posedge i_clk);
        want <= w;
        free <= f;
        expq.push_back(e1);
        if (e2 !== NO) expq.push_back(e2);
        for (n = 0; n < 20 && expq.size() > 0; n++) @(posedge i_clk);
        if (expq.size() > 0) begin
            fails++;
            give_verdict();
        end
    endtask
    task automatic idle_rand;
        int n;
        for (n = 0; n < 8; n++) begin
            @(posedge i_clk);
            rnd = lfsr(rnd);
            {i_control_cycle_strobe_n, i_latched_write} <= rnd[3:2];
            {i_latched_addr_bit2, i_ctrl_irq} <= rnd[1:0];
            @(posedge i_clk);
            @(negedge i_clk);
            cmp({1'b0, o_ctrl_read_strobe_n, o_ctrl_write_strobe_n,
                 o_reg_file_select, o_host_irq_n},
                {1'b0, rnd[3] | rnd[2], rnd[3] | ~rnd[2], rnd[1], ~rnd[0]});
        end
    endtask
    initial begin
        int sp;
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        for (sp = 0; sp < 2; sp++) begin
            i_speed_16m <= sp[0];
            idle_rand();
            go(1'b1, 1'b0, {DBAFSM_PENDING, 2'h1}, NO);
            go(1'b1, 1'b1, {DBAFSM_ACTIVE, 2'h3}, NO);
            repeat (3) begin
                @(negedge i_clk);
                cmp({3'h0, o_ctrl_read_strobe_n, o_ctrl_write_strobe_n},
                    {3'h0, i_chip_read_strobe_n, i_chip_write_strobe_n});
            end
            go(1'b1, 1'b0, {DBAFSM_THROTTLE, 2'h1}, NO);
            go(1'b1, 1'b1, {DBAFSM_KICKSTART, 2'h3}, {DBAFSM_ACTIVE, 2'h3});
            go(1'b1, 1'b0, {DBAFSM_THROTTLE, 2'h1}, NO);
            go(1'b0, 1'b1, {DBAFSM_KICKSTART, 2'h1}, {DBAFSM_IDLE, 2'h0});
            go(1'b1, 1'b1, {DBAFSM_PENDING, 2'h1}, {DBAFSM_ACTIVE, 2'h3});
            // select and data request dropped together park the machine in throttle
            go(1'b0, 1'b0, {DBAFSM_THROTTLE, 2'h1}, NO);
            go(1'b0, 1'b1, {DBAFSM_KICKSTART, 2'h1}, {DBAFSM_IDLE, 2'h0});
            go(1'b1, 1'b1, {DBAFSM_PENDING, 2'h1}, {DBAFSM_ACTIVE, 2'h3});
            go(1'b0, 1'b1, {DBAFSM_IDLE, 2'h0}, NO);
            go(1'b1, 1'b0, {DBAFSM_PENDING, 2'h1}, NO);
            i_ctrl_chip_reset <= 1'b1;
            go(1'b0, 1'b0, {DBAFSM_IDLE, 2'h0}, NO);
            i_ctrl_chip_reset <= 1'b0;
        end
        give_verdict();
    end
endmodule
`default_nettype wire
